// ===== vbfs_host_model.sv
`timescale 1ns/100ps
module vbfs_host_model (
  // Resolved data wire
  input wire logic sda_i,
  // Host pin drives; pull high means the host pulls data low
  output logic scl_o,
  output logic pull_o
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  task automatic pins(input logic c, input logic d);
    scl_o = c;
    pull_o = !d;
  endtask : pins

  // Link clock runs only inside a frame; ack slots left released
  // Eighteen clocks: address, its ack, data, then the data ack before the stop
  task automatic send(input logic [7:0] a, input logic [7:0] d, output logic [1:0] ack);
    logic [17:0] bits;
    bits = {a, 1'b1, d, 1'b1};
    ack = 2'b00;
    scl_o = 1'b1;
    pull_o = 1'b0;
    #29;
    pull_o = 1'b1;
    #24;
    for (int i = 17; i >= 0; i--) begin
      scl_o = 1'b0;
      #12;
      pull_o = !bits[i];
      #12;
      scl_o = 1'b1;
      #12;
      if (i == 9) ack[1] = !sda_i;
      if (i == 0) ack[0] = !sda_i;
      #12;
    end
    scl_o = 1'b0;
    #12;
    pull_o = 1'b1;
    #12;
    scl_o = 1'b1;
    #12;
    pull_o = 1'b0;
    #24;
  endtask : send
endmodule : vbfs_host_model

// ===== vbfs_pkg.sv
// Overview of operation
// - Enable rise, no power-ok: latch boot code.
// - Reapply stored boot code when power-ok drops outside fixed mode.
// - Commands ignored without power-ok or in fixed mode; otherwise followed.
// - Eight-bit address and data, three addresses.
// - Data bit 7 low drives power-save low.
// - Low seven data bits load addressed DACs.
// - Enable with power-ok high: fixed voltage mode.
// - Enable, no fault: charge; boot code stored only without power-ok.
// - Clamp error amp until offset comparator trips.
// - Output good only above delay threshold.
// - Undervoltage, overcurrent, enable low set soft fault.
// - Discharged comparator clears soft fault once cleared.
// - Overvoltage, open sense, open phase latch hard.
// - Off code discharges, clamps, keeps output good.
// - Non-off code after off restarts soft-start.
// - Disable comparator low means converter disabled.
// - Boot code map 00..11 to 1.1..0.8 V.
// - Fixed code map 00..11 to 1.4..0.8 V.
// - Address 110xx100 core, 110xx010 aux, 110xx110 both.
// - Non-off code updates DACs right after data.
package vbfs_pkg;

  localparam int VBFS_CODE_W = 7;
  localparam int VBFS_CNT_W = 5;

  // Serial frame positions, counted in link clock rising edges
  localparam logic [4:0] VBFS_CNT_ADDR_ACK = 5'h08;
  localparam logic [4:0] VBFS_CNT_DATA_LAST = 5'h10;
  localparam logic [4:0] VBFS_CNT_DATA_ACK = 5'h11;
  localparam logic [4:0] VBFS_CNT_IDLE = 5'h12;

  // Address byte including write bit
  localparam logic [2:0] VBFS_ADDR_HIGH = 3'h6;
  localparam logic [2:0] VBFS_ADDR_CORE = 3'h4;
  localparam logic [2:0] VBFS_ADDR_AUX = 3'h2;
  localparam logic [2:0] VBFS_ADDR_BOTH = 3'h6;

  localparam logic [6:0] VBFS_OFF_CODE_MIN = 7'h7c;
  localparam logic [6:0] VBFS_DAC_RESET = 7'h7c;
  localparam logic [7:0] VBFS_CMD_RESET = 8'h00;

  // Two-bit codes translated to seven-bit DAC codes, indexed by {clock, data}
  localparam logic [6:0] VBFS_BOOT_LUT [4] = '{7'h24, 7'h2c, 7'h34, 7'h3c};
  localparam logic [6:0] VBFS_FIX_LUT [4] = '{7'h0c, 7'h1c, 7'h2c, 7'h3c};

  // Synchronised input vector positions
  localparam int VBFS_SYNC_N = 13;
  localparam int VBFS_IN_EN = 0;
  localparam int VBFS_IN_POK = 1;
  localparam int VBFS_IN_SCL = 2;
  localparam int VBFS_IN_SDA = 3;
  localparam int VBFS_IN_UV = 4;
  localparam int VBFS_IN_OC = 5;
  localparam int VBFS_IN_OV = 6;
  localparam int VBFS_IN_OPEN_SENSE = 7;
  localparam int VBFS_IN_OPEN_PHASE = 8;
  localparam int VBFS_IN_OFS = 9;
  localparam int VBFS_IN_DELAY = 10;
  localparam int VBFS_IN_DISCH = 11;
  localparam int VBFS_IN_DISABLE = 12;

  typedef enum logic [1:0] {
    VBFS_ST_FAULT = 2'b00,
    VBFS_ST_RUN = 2'b01,
    VBFS_ST_OFF = 2'b10
  } vbfs_state_t;

endpackage : vbfs_pkg

// ===== vbfs_sequencer.sv
`timescale 1ns/100ps
module vbfs_sequencer
  import vbfs_pkg::*;
(
  // System clock and bias-rail reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control pins
  input wire logic enable_i,
  input wire logic system_power_ok_i,
  // Serial command pins; the clock pin also clocks the link logic
  input wire logic serial_cmd_clock_i,
  input wire logic serial_cmd_data_i,
  output logic serial_cmd_data_o,
  output logic serial_cmd_data_oe_n_o,
  // Fault detector levels
  input wire logic bias_undervoltage_i,
  input wire logic overcurrent_i,
  input wire logic overvoltage_i,
  input wire logic remote_sense_open_i,
  input wire logic phase_loop_open_i,
  // Soft-start comparator levels
  input wire logic ss_offset_reached_i,
  input wire logic ss_delay_reached_i,
  input wire logic ss_discharged_i,
  input wire logic ss_disable_low_i,
  // Reference and converter control
  output logic [VBFS_CODE_W-1:0] core_reference_dac_o,
  output logic [VBFS_CODE_W-1:0] aux_reference_dac_o,
  output logic power_save_out_n_o,
  output logic softstart_charge_o,
  output logic softstart_discharge_o,
  output logic error_amp_clamp_o,
  output logic output_good_o,
  // Status
  output logic fixed_voltage_mode_o,
  output logic soft_fault_o,
  output logic hard_fault_o,
  output logic converter_disabled_o
);

  // ---------------- Link domain ----------------
  logic start_tog_q;
  logic seen_tog_q;
  logic [VBFS_CNT_W-1:0] cnt_q;
  logic [7:0] shift_q;
  logic frame_ok_q;
  logic sel_core_q;
  logic sel_aux_q;
  logic [7:0] cmd_byte_q;
  logic cmd_core_q;
  logic cmd_aux_q;
  logic cmd_tog_q;
  logic ack_q;
  logic pok_l1_q;
  logic pok_l2_q;

  wire start_seen = start_tog_q != seen_tog_q;
  wire at_addr_ack = cnt_q == VBFS_CNT_ADDR_ACK;
  wire at_data_last = cnt_q == VBFS_CNT_DATA_LAST;
  wire at_data_ack = cnt_q == VBFS_CNT_DATA_ACK;
  wire in_frame = cnt_q != VBFS_CNT_IDLE;
  wire addr_core = shift_q[2:0] == VBFS_ADDR_CORE;
  wire addr_aux = shift_q[2:0] == VBFS_ADDR_AUX;
  wire addr_both = shift_q[2:0] == VBFS_ADDR_BOTH;
  wire addr_hit = (shift_q[7:5] == VBFS_ADDR_HIGH) && (addr_core || addr_aux || addr_both);
  wire addr_take = at_addr_ack && addr_hit && pok_l2_q;
  wire [7:0] data_full = {shift_q[6:0], serial_cmd_data_i};

  // Start is data falling while the clock is high; a toggle carries it to the link logic,
  // which sees it one bit period later at the next rising clock edge.
  always_ff @(negedge serial_cmd_data_i or posedge rst_i) begin
    if (rst_i) begin
      start_tog_q <= 1'b0;
    end else if (serial_cmd_clock_i) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  always_ff @(posedge serial_cmd_clock_i or posedge rst_i) begin
    if (rst_i) begin
      pok_l1_q <= 1'b0;
      pok_l2_q <= 1'b0;
    end else begin
      pok_l1_q <= system_power_ok_i;
      pok_l2_q <= pok_l1_q;
    end
  end

  // Address bits sampled on the start edge and at counts 1..7, address ack at 8, data at 9..16, data ack at 17
  always_ff @(posedge serial_cmd_clock_i or posedge rst_i) begin
    if (rst_i) begin
      seen_tog_q <= 1'b0;
      cnt_q <= VBFS_CNT_IDLE;
      shift_q <= 8'h00;
    end else if (start_seen) begin
      seen_tog_q <= start_tog_q;
      cnt_q <= 5'h01;
      shift_q <= {7'h00, serial_cmd_data_i};
    end else if (in_frame) begin
      cnt_q <= (at_addr_ack && !addr_take) ? VBFS_CNT_IDLE : cnt_q + 5'h01;
      shift_q <= {shift_q[6:0], serial_cmd_data_i};
    end
  end

  always_ff @(posedge serial_cmd_clock_i or posedge rst_i) begin
    if (rst_i) begin
      frame_ok_q <= 1'b0;
      sel_core_q <= 1'b0;
      sel_aux_q <= 1'b0;
    end else if (at_addr_ack) begin
      frame_ok_q <= addr_take;
      sel_core_q <= shift_q[2];
      sel_aux_q <= shift_q[1];
    end
  end

  // Command word is held until the next full frame, so the toggle crossing is safe
  always_ff @(posedge serial_cmd_clock_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_byte_q <= VBFS_CMD_RESET;
      cmd_core_q <= 1'b0;
      cmd_aux_q <= 1'b0;
      cmd_tog_q <= 1'b0;
    end else if (at_data_last && frame_ok_q) begin
      cmd_byte_q <= data_full;
      cmd_core_q <= sel_core_q;
      cmd_aux_q <= sel_aux_q;
      cmd_tog_q <= ~cmd_tog_q;
    end
  end

  // Ack changes on the falling edge so data never moves while the clock is high
  always_ff @(negedge serial_cmd_clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= addr_take || (at_data_ack && frame_ok_q);
    end
  end

  assign serial_cmd_data_o = 1'b0;
  assign serial_cmd_data_oe_n_o = ~ack_q;

  // ---------------- System domain ----------------
  logic [VBFS_SYNC_N-1:0] async_in;
  logic [VBFS_SYNC_N-1:0] sync1_q;
  logic [VBFS_SYNC_N-1:0] sync2_q;

  assign async_in = {ss_disable_low_i, ss_discharged_i, ss_delay_reached_i, ss_offset_reached_i,
                     phase_loop_open_i, remote_sense_open_i, overvoltage_i, overcurrent_i,
                     bias_undervoltage_i, serial_cmd_data_i, serial_cmd_clock_i,
                     system_power_ok_i, enable_i};

  for (genvar i = 0; i < VBFS_SYNC_N; i++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else if (ce_i) begin
        sync1_q[i] <= async_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  wire en_s = sync2_q[VBFS_IN_EN];
  wire pok_s = sync2_q[VBFS_IN_POK];
  wire [1:0] pin_code = {sync2_q[VBFS_IN_SCL], sync2_q[VBFS_IN_SDA]};
  wire soft_cause = sync2_q[VBFS_IN_UV] || sync2_q[VBFS_IN_OC] || !en_s;
  wire hard_cause = sync2_q[VBFS_IN_OV] || sync2_q[VBFS_IN_OPEN_SENSE]
                    || sync2_q[VBFS_IN_OPEN_PHASE];
  wire ofs_s = sync2_q[VBFS_IN_OFS];
  wire delay_s = sync2_q[VBFS_IN_DELAY];
  wire disch_s = sync2_q[VBFS_IN_DISCH];
  wire disable_s = sync2_q[VBFS_IN_DISABLE];

  logic ctog1_q;
  logic ctog2_q;
  logic ctog3_q;
  logic en_d1_q;
  logic pok_d1_q;
  logic [1:0] boot_q;
  logic fixed_q;
  logic soft_fault_q;
  logic hard_fault_q;
  logic [VBFS_CODE_W-1:0] core_q;
  logic [VBFS_CODE_W-1:0] aux_q;
  logic psi_n_q;
  logic good_q;
  vbfs_state_t st_q;
  vbfs_state_t st_d;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctog1_q <= 1'b0;
      ctog2_q <= 1'b0;
      ctog3_q <= 1'b0;
      en_d1_q <= 1'b0;
      pok_d1_q <= 1'b0;
    end else if (ce_i) begin
      ctog1_q <= cmd_tog_q;
      ctog2_q <= ctog1_q;
      ctog3_q <= ctog2_q;
      en_d1_q <= en_s;
      pok_d1_q <= pok_s;
    end
  end

  wire cmd_evt = ctog2_q ^ ctog3_q;
  wire en_rise = en_s && !en_d1_q;
  wire pok_fall = !pok_s && pok_d1_q;
  wire cmd_live = cmd_evt && pok_s && !fixed_q;
  wire [6:0] cmd_code = cmd_byte_q[6:0];
  wire cmd_off = cmd_code >= VBFS_OFF_CODE_MIN;
  wire cmd_load = cmd_live && !cmd_off;
  wire any_fault = soft_fault_q || hard_fault_q;
  wire [6:0] boot_dac = VBFS_BOOT_LUT[pin_code];
  wire [6:0] fix_dac = VBFS_FIX_LUT[pin_code];
  wire [6:0] stored_dac = VBFS_BOOT_LUT[boot_q];

  // Fault latches; a new cause wins over the discharge-driven clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_fault_q <= 1'b1;
      hard_fault_q <= 1'b0;
    end else if (ce_i) begin
      soft_fault_q <= soft_cause || (soft_fault_q && !disch_s);
      hard_fault_q <= hard_fault_q || hard_cause;
    end
  end

  // Boot code (only without power ok) and fixed mode flag are latched on the enable edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= 2'b00;
      fixed_q <= 1'b0;
    end else if (ce_i && en_rise) begin
      fixed_q <= pok_s;
      if (!pok_s) begin
        boot_q <= pin_code;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_q <= VBFS_DAC_RESET;
      aux_q <= VBFS_DAC_RESET;
      psi_n_q <= 1'b1;
    end else if (ce_i) begin
      if (en_rise) begin
        core_q <= pok_s ? fix_dac : boot_dac;
        aux_q <= pok_s ? fix_dac : boot_dac;
      end else if (pok_fall && !fixed_q) begin
        core_q <= stored_dac;
        aux_q <= stored_dac;
        psi_n_q <= 1'b1;
      end else if (cmd_live) begin
        psi_n_q <= cmd_byte_q[7];
        if (!cmd_off && cmd_core_q) begin
          core_q <= cmd_code;
        end
        if (!cmd_off && cmd_aux_q) begin
          aux_q <= cmd_code;
        end
      end
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      VBFS_ST_FAULT: if (!any_fault) st_d = VBFS_ST_RUN;
      VBFS_ST_RUN: if (cmd_live && cmd_off) st_d = VBFS_ST_OFF;
      VBFS_ST_OFF: if (cmd_load) st_d = VBFS_ST_RUN;
      default: st_d = VBFS_ST_FAULT;
    endcase
    if (any_fault) begin
      st_d = VBFS_ST_FAULT;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= VBFS_ST_FAULT;
      good_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      if (st_d == VBFS_ST_FAULT) begin
        good_q <= 1'b0;
      end else if (st_d == VBFS_ST_RUN) begin
        good_q <= delay_s && !disable_s;
      end
    end
  end

  wire running = (st_q == VBFS_ST_RUN) && !any_fault;

  assign softstart_charge_o = running;
  assign softstart_discharge_o = !running;
  assign error_amp_clamp_o = !running || !ofs_s || disable_s;
  assign output_good_o = good_q;
  assign converter_disabled_o = disable_s;
  assign core_reference_dac_o = core_q;
  assign aux_reference_dac_o = aux_q;
  assign power_save_out_n_o = psi_n_q;
  assign fixed_voltage_mode_o = fixed_q;
  assign soft_fault_o = soft_fault_q;
  assign hard_fault_o = hard_fault_q;

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_BOOT_APPLY: assert property (ce_i && en_rise && !pok_s |=>
    core_q == VBFS_BOOT_LUT[$past(pin_code)] && aux_q == core_q)
    else $error("boot code not applied");
  AST_POK_DROP: assert property (ce_i && pok_fall && !fixed_q && !en_rise |=>
    core_q == VBFS_BOOT_LUT[boot_q] && aux_q == core_q)
    else $error("boot code not reapplied");
  AST_CMD_IGNORED: assert property (ce_i && cmd_evt && (!pok_s || fixed_q) && !en_rise && !pok_fall |=>
    $stable(core_q) && $stable(aux_q))
    else $error("command taken before power ok");
  AST_PSI: assert property (ce_i && cmd_live && !en_rise && !pok_fall |=>
    psi_n_q == $past(cmd_byte_q[7]))
    else $error("power save bit not applied");
  AST_FIXED: assert property (ce_i && en_rise && pok_s |=>
    fixed_q && core_q == VBFS_FIX_LUT[$past(pin_code)])
    else $error("fixed mode not entered");
  AST_CLAMP: assert property (!ofs_s |-> error_amp_clamp_o)
    else $error("error amp not clamped");
  AST_GOOD: assert property ($rose(output_good_o) |-> $past(delay_s))
    else $error("output good before delay threshold");
  AST_FAULT: assert property (ce_i && any_fault |-> softstart_discharge_o ##1 !output_good_o)
    else $error("fault did not shut down");
  AST_HARD: assert property (hard_fault_q |=> hard_fault_q [*4])
    else $error("hard fault latch cleared");
  AST_OFF: assert property (ce_i && running && cmd_live && cmd_off && !hard_cause && !soft_cause
    |=> st_q == VBFS_ST_OFF && $stable(output_good_o))
    else $error("off code mishandled");

endmodule : vbfs_sequencer

// ===== vbfs_sequencer_test.sv
`timescale 1ns/100ps
module vbfs_sequencer_test;
  import vbfs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, pok = 1'b0;
  logic [4:0] flt = 5'h00;
  logic ofs = 1'b0, dly = 1'b0, dsb = 1'b0, dsc = 1'b1;
  logic scl, pull, sda, oe_n, sda_o, psi_n, chg, dis, clamp, good, fixm, sf, hf, cdis;
  logic [6:0] core, aux;
  logic [1:0] ack;
  int errors = 0;
  int compares = 0;
  int seed = 32'hc67e_9a7e;
  always #2 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda = !(pull || (!oe_n && !sda_o));

  vbfs_sequencer vbfs_sequencer_inst (.clk_i(clk), .rst_i(rst), .ce_i(1'b1),
    .enable_i(en), .system_power_ok_i(pok), .serial_cmd_clock_i(scl),
    .serial_cmd_data_i(sda), .serial_cmd_data_o(sda_o), .serial_cmd_data_oe_n_o(oe_n),
    .bias_undervoltage_i(flt[0]), .overcurrent_i(flt[1]), .overvoltage_i(flt[2]),
    .remote_sense_open_i(flt[3]), .phase_loop_open_i(flt[4]), .ss_offset_reached_i(ofs),
    .ss_delay_reached_i(dly), .ss_discharged_i(dsc), .ss_disable_low_i(dsb),
    .core_reference_dac_o(core), .aux_reference_dac_o(aux), .power_save_out_n_o(psi_n),
    .softstart_charge_o(chg), .softstart_discharge_o(dis), .error_amp_clamp_o(clamp),
    .output_good_o(good), .fixed_voltage_mode_o(fixm), .soft_fault_o(sf),
    .hard_fault_o(hf), .converter_disabled_o(cdis));
  vbfs_host_model vbfs_host_model_inst (.sda_i(sda), .scl_o(scl), .pull_o(pull));

  function automatic logic [6:0] boot_code(input logic [1:0] c);
    return 7'h24 + {2'b00, c, 3'b000};
  endfunction : boot_code
  function automatic logic [6:0] fix_code(input logic [1:0] c);
    return 7'h0c + {1'b0, c, 4'h0};
  endfunction : fix_code

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk_code(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: code %h expected %h", $time, got, exp);
    end
  endtask : chk_code
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // Eight cycles covers the two-flop synchroniser plus the output register
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    vbfs_host_model_inst.send(a, d, ack);
    wt(2);
  endtask : cmd

  initial begin
    #200000;
    errors++;
    test_done();
  end

  initial begin
    logic [1:0] c;
    logic [7:0] a, d;
    logic [6:0] ec, ea, bc;
    logic ep;
    wt(8);
    chk_code(core, 7'h7c);
    chk_bit(psi_n, 1'b1);
    chk_bit(oe_n, 1'b1);
    rst = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      for (int k = 0; k < 4; k++) begin
        c = 2'(k);
        en = 1'b0;
        pok = m[0];
        vbfs_host_model_inst.pins(c[1], c[0]);
        wt(8);
        chk_bit(sf, 1'b1);
        en = 1'b1;
        wt(8);
        vbfs_host_model_inst.pins(1'b1, 1'b1);
        bc = m[0] ? fix_code(c) : boot_code(c);
        chk_code(core, bc);
        chk_code(aux, bc);
        chk_bit(fixm, m[0]);
        chk_bit(chg, 1'b1);
      end
    end
    chk_bit(clamp, 1'b1);
    cmd(8'hc4, 8'h90);
    chk_bit(ack[1], 1'b0);
    chk_code(core, bc);
    pok = 1'b1;
    wt(8);
    ec = bc;
    ea = bc;
    ep = 1'b1;
    for (int i = 0; i < 15; i++) begin
      a = {3'b110, 2'($random(seed)), 3'b000};
      a[2:1] = (i % 3 == 0) ? 2'b10 : (i % 3 == 1) ? 2'b01 : 2'b11;
      if (i == 14) a[7] = 1'b0;
      d = 8'($random(seed));
      if (d[6:0] >= 7'h7c || i == 13) d[6:0] = 7'h7b;
      cmd(a, d);
      if (a[7]) begin
        ec = a[2] ? d[6:0] : ec;
        ea = a[1] ? d[6:0] : ea;
        ep = d[7];
      end
      chk_bit(ack[1], a[7]);
      chk_bit(ack[0], a[7]);
      chk_code(core, ec);
      chk_code(aux, ea);
      chk_bit(psi_n, ep);
    end
    pok = 1'b0;
    wt(8);
    chk_code(core, bc);
    chk_code(aux, bc);
    pok = 1'b1;
    ofs = 1'b1;
    dly = 1'b1;
    wt(8);
    chk_bit(clamp, 1'b0);
    chk_bit(good, 1'b1);
    for (int k = 0; k < 4; k++) begin
      cmd(8'hde, {1'b1, 7'h7c + 7'(k)});
      chk_bit(chg, 1'b0);
      chk_bit(dis, 1'b1);
      chk_bit(clamp, 1'b1);
      chk_bit(good, 1'b1);
      d = {1'b1, 7'($random(seed)) & 7'h3f};
      cmd(8'hc6, d);
      chk_bit(chg, 1'b1);
      chk_code(aux, d[6:0]);
    end
    dsb = 1'b1;
    wt(8);
    chk_bit(cdis, 1'b1);
    chk_bit(good, 1'b0);
    dsb = 1'b0;
    dly = 1'b0;
    wt(8);
    chk_bit(good, 1'b0);
    dly = 1'b1;
    for (int j = 0; j < 5; j++) begin
      flt[j] = 1'b1;
      wt(8);
      chk_bit(good, 1'b0);
      chk_bit(clamp, 1'b1);
      chk_bit(j < 2 ? sf : hf, 1'b1);
      flt[j] = 1'b0;
      dsc = (j >= 2);
      wt(8);
      chk_bit(sf, j < 2);
      dsc = 1'b1;
      wt(8);
      chk_bit(j < 2 ? sf : hf, j >= 2);
      rst = (j >= 2);
      wt(2);
      rst = 1'b0;
      wt(8);
      chk_bit(hf, 1'b0);
    end
    // Reset with enable and power ok high re-enters fixed mode; commands are then ignored
    chk_bit(fixm, 1'b1);
    cmd(8'hc6, 8'h10);
    chk_bit(ack[1], 1'b1);
    chk_code(core, fix_code(2'b11));
    test_done();
  end
endmodule : vbfs_sequencer_test
